//--- rtl/mfs_pkg.sv
// Package for the motor fault shutdown latch: register map, field layout and timing constants.
package mfs_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] CONFIG_ADDR = 8'h08;
	// ==========================================================
	// Field positions
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int STAT_THERMAL_BIT = 0;
	localparam int STAT_OC_A_BIT = 1;
	localparam int STAT_OC_B_BIT = 2;
	localparam int STAT_STANDBY_BIT = 3;
	localparam int STAT_BRIDGE_A_BIT = 4;
	localparam int STAT_BRIDGE_B_BIT = 5;
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_DIV_W = 8;
	// ==========================================================
	// Reset values and timing
	localparam logic [7:0] CFG_DIV_RESET = 8'h0B;
	localparam int OC_MASK_CYCLES = 4;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// ==========================================================
	// Excitation mode select
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_TWO_PHASE = 2'h1,
		MODE_ONE_TWO = 2'h2,
		MODE_W_ONE_TWO = 2'h3
	} mfs_mode_t;
	typedef struct packed {
		logic thermal;
		logic [1:0] overcurrent;
		logic standby;
		logic [1:0] bridge_on;
	} mfs_status_t;
endpackage

//--- rtl/mfs_chopper_osc.sv
// Chopper oscillator tick generator, stopped while the device is in standby.
`timescale 1ns/100ps
module mfs_chopper_osc #(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic run,
	input wire logic [DIV_W-1:0] half_div,
	// Tick out
	output logic tick
);
	logic [DIV_W-1:0] count;

	// The counter is held at zero while stopped, so the first tick after a restart comes a full period later.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count >= half_div) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

//--- rtl/mfs_oc_qualifier.sv
// Overcurrent masking counter for one motor phase.
`timescale 1ns/100ps
module mfs_oc_qualifier #(
	parameter int MASK_CYCLES = mfs_pkg::OC_MASK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Detector and oscillator
	input wire logic oc_raw,
	input wire logic osc_tick,
	// Qualified trip pulse
	output logic trip
);
	localparam int CW = $clog2(MASK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(MASK_CYCLES - 1);
	logic [CW-1:0] count;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			trip <= 1'b0;
		end else if (!oc_raw) begin
			count <= '0;
			trip <= 1'b0;
		end else if (osc_tick) begin
			if (count == LAST) begin
				count <= '0;
				trip <= 1'b1;
			end else begin
				count <= count + 1'b1;
				trip <= 1'b0;
			end
		end else begin
			trip <= 1'b0;
		end
	end
endmodule

//--- rtl/mfs_fault_latch.sv
// Fault shutdown latch for a two-phase stepping motor bridge, with AXI4-Lite status and control.
//
// Contract
// - A thermal trip forces every bridge transistor off at once.
// - After a thermal trip the bridge stays off until both mode selects are low or reset; the code also releases it on a software clear.
// - A qualified overcurrent trip forces the bridge off.
// - Overcurrent counts as a trip only after lasting four chopper oscillator cycles.
// - After the overcurrent latch is released, normal drive resumes within four oscillator cycles.
// - The overcurrent latch holds until both mode selects are low or reset, not on current decay.
// - While the overcurrent latch is set the device behaves as standby, oscillator and bridge off.
// - Both mode selects low means standby with oscillator and bridge off.
// - Each phase has its own overcurrent detector; its trip shuts off its own phase at once, and the latch then shuts off both phases.
`timescale 1ns/100ps
module mfs_fault_latch #(
	parameter int PHASES = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Host mode select and detectors
	input wire logic [1:0] mode_select,
	input wire logic thermal_trip,
	input wire logic [PHASES-1:0] overcurrent_trip,
	// Drive requests from the chopper logic, one per phase
	input wire logic [PHASES-1:0] drive_request,
	// Bridge and oscillator control
	output logic [PHASES-1:0] bridge_enable,
	output logic chopper_oscillator,
	output logic chopper_tick,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================================
	// State
	logic standby;
	logic thermal_latched;
	logic [PHASES-1:0] oc_latched;
	logic [PHASES-1:0] oc_qualified;
	logic sw_clear;
	logic [7:0] half_div;
	logic osc_run;
	logic [PHASES-1:0] next_bridge;
	mfs_pkg::mfs_status_t status;

	assign standby = (mfs_pkg::mfs_mode_t'(mode_select) == mfs_pkg::MODE_STANDBY);

	// ==========================================================
	// Fault latches
	// Trip wins over a clear that lands in the same cycle, so no event is lost.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			thermal_latched <= 1'b0;
		end else if (thermal_trip) begin
			thermal_latched <= 1'b1;
		end else if (standby || sw_clear) begin
			thermal_latched <= 1'b0;
		end
	end

	// The thermal input also gates the bridge directly, so the cycle before the latch catches it is covered.
	a_thermal_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		thermal_trip |-> bridge_enable == '0) else $error("bridge on during thermal trip");
	a_thermal_catch: assert property (@(posedge sys_clk) disable iff (!reset_n)
		thermal_trip |=> thermal_latched) else $error("thermal trip not latched");
	a_thermal_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		thermal_latched && !standby && !sw_clear |=> thermal_latched) else $error("thermal latch lost");
	a_sw_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sw_clear && !thermal_trip |=> !thermal_latched) else $error("software clear ignored");

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oc_latched <= '0;
		end else begin
			for (int i = 0; i < PHASES; i++) begin
				if (oc_qualified[i]) begin
					oc_latched[i] <= 1'b1;
				end else if (standby) begin
					oc_latched[i] <= 1'b0;
				end
			end
		end
	end

	a_oc_latch_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		oc_latched[0] && !standby |=> oc_latched[0]) else $error("oc latch cleared early");
	a_oc_standby: assert property (@(posedge sys_clk) disable iff (!reset_n)
		oc_latched != '0 |-> bridge_enable == '0 && !osc_run) else $error("oc latch not standby");
	// A trip that lands in the first standby cycle still latches, so only a quiet qualifier must clear.
	a_standby_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		standby && oc_qualified == '0 |=> !chopper_oscillator ##0 oc_latched == '0)
		else $error("standby not honoured");

	// ==========================================================
	// Oscillator and per-phase qualifiers
	// Any latched overcurrent parks the whole device in standby, so the oscillator stops too.
	assign osc_run = !standby && (oc_latched == '0);

	mfs_chopper_osc #(
		.DIV_W(mfs_pkg::CFG_DIV_W)
	) u_osc (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(osc_run),
		.half_div(half_div),
		.tick(chopper_tick)
	);

	a_tick_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!osc_run |=> !chopper_tick) else $error("tick while oscillator stopped");

	// The oscillator stops while a phase is latched, but the qualifier only counts while running.
	generate
		for (genvar p = 0; p < PHASES; p++) begin : g_phase
			mfs_oc_qualifier u_qual (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.oc_raw(overcurrent_trip[p]),
				.osc_tick(chopper_tick),
				.trip(oc_qualified[p])
			);
			a_phase_own: assert property (@(posedge sys_clk) disable iff (!reset_n)
				oc_qualified[p] |-> !bridge_enable[p]) else $error("phase on during its own trip");
		end
	endgenerate

	// Any oscillator rate gives at most one tick a cycle, so four ticks need four cycles of overcurrent.
	a_oc_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(oc_qualified[0]) |-> $past(overcurrent_trip[0], 1) && $past(overcurrent_trip[0], 2)
		&& $past(overcurrent_trip[0], 3) && $past(overcurrent_trip[0], 4)) else $error("oc trip without persist");
	a_short_oc: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!overcurrent_trip[1] |=> !oc_qualified[1]) else $error("trip without overcurrent");

	// ==========================================================
	// Bridge gating
	// The thermal input gates the bridge combinationally in the same cycle, before the latch catches it.
	always_comb begin
		for (int i = 0; i < PHASES; i++) begin
			next_bridge[i] = drive_request[i] && !standby && !thermal_trip && !thermal_latched
				&& (oc_latched == '0) && !oc_qualified[i];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			chopper_oscillator <= 1'b0;
		end else begin
			chopper_oscillator <= osc_run;
		end
	end

	assign bridge_enable = next_bridge;

	// The oscillator flag is registered, so it drops one cycle after the bridge does.
	a_oc_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		oc_qualified != '0 |=> bridge_enable == '0 ##1 !chopper_oscillator) else $error("bridge on after oc");
	a_resume_fast: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(standby) && oc_latched == '0 |=> chopper_oscillator) else $error("no resume after release");
	a_bridge_standby: assert property (@(posedge sys_clk) disable iff (!reset_n)
		standby |-> bridge_enable == '0) else $error("bridge on in standby");
	a_bridge_request: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(bridge_enable & ~drive_request) == '0) else $error("bridge on without request");

	// ==========================================================
	// AXI4-Lite slave
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= mfs_pkg::AXI_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr == mfs_pkg::CTRL_ADDR || aw_addr == mfs_pkg::CONFIG_ADDR
				|| aw_addr == mfs_pkg::STATUS_ADDR) ? mfs_pkg::AXI_OKAY : mfs_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Address and data are refused while a response waits, so one write is in flight at most.
	a_aw_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_bvalid |-> !s_axi_awready) else $error("write address taken during response");
	a_w_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_bvalid |-> !s_axi_wready) else $error("write data taken during response");
	a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

	// Software clear only releases the thermal latch; an overcurrent needs the mode pins.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_clear <= 1'b0;
		end else begin
			sw_clear <= do_write && aw_addr == mfs_pkg::CTRL_ADDR && w_strb[0]
				&& w_data[mfs_pkg::CTRL_CLEAR_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_div <= mfs_pkg::CFG_DIV_RESET;
		end else if (do_write && aw_addr == mfs_pkg::CONFIG_ADDR && w_strb[0]) begin
			half_div <= w_data[mfs_pkg::CFG_DIV_LSB +: mfs_pkg::CFG_DIV_W];
		end
	end

	assign status.thermal = thermal_latched;
	assign status.overcurrent = oc_latched[1:0];
	assign status.standby = standby || (oc_latched != '0);
	assign status.bridge_on = bridge_enable[1:0];
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= mfs_pkg::AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mfs_pkg::AXI_OKAY;
			case (s_axi_araddr)
				mfs_pkg::CTRL_ADDR: begin
					s_axi_rdata <= 32'h00000000;
				end
				mfs_pkg::STATUS_ADDR: begin
					s_axi_rdata <= {26'h0000000, status.bridge_on[1], status.bridge_on[0], status.standby,
						status.overcurrent[1], status.overcurrent[0], status.thermal};
				end
				mfs_pkg::CONFIG_ADDR: begin
					s_axi_rdata <= {24'h000000, half_div};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= mfs_pkg::AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// The read answer comes one edge after the address is taken and stands until rready.
	a_rd_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read response");
	a_ar_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_rvalid |-> !s_axi_arready) else $error("read address taken during response");
	a_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

//--- tb/mfs_host_model.sv
// Host controller model that drives the excitation mode select pins.
`timescale 1ns/100ps
module mfs_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Requested mode from the bench
	input wire logic [1:0] want_mode,
	// Mode select pins
	output logic [1:0] mode_select
);
	// The pins sit at standby out of reset, so the motor stays idle as supply returns.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_select <= mfs_pkg::MODE_STANDBY;
		end else begin
			mode_select <= want_mode;
		end
	end
endmodule

//--- tb/test_motor_fault_shutdown_latch.sv
// Self-checking bench for the motor fault shutdown latch.
`timescale 1ns/100ps
module test_motor_fault_shutdown_latch;
	logic sys_clk = 0, reset_n = 0, thermal_trip = 0, chopper_oscillator, chopper_tick;
	logic [1:0] want_mode = 0, mode_select, overcurrent_trip = 0, drive_request = 2'h3, bridge_enable;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
	logic arvalid = 0, arready, rvalid, rready = 0;
	logic [1:0] bresp, rresp, rs;
	int err_total = 0, n_checks = 0, cycles = 0;
	mfs_host_model u_host (.sys_clk(sys_clk), .reset_n(reset_n), .want_mode(want_mode), .mode_select(mode_select));
	mfs_fault_latch u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .mode_select(mode_select),
		.thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip), .drive_request(drive_request),
		.bridge_enable(bridge_enable), .chopper_oscillator(chopper_oscillator), .chopper_tick(chopper_tick),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// Checks and bus tasks
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bits(input logic [1:0] got, input logic [1:0] exp, input string m);
		chk_word({30'h0, got}, {30'h0, exp}, m);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Handshakes are decided at the falling edge and released after the rising edge that completes them.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ap, wp, ah, wh, b;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		ap = 1;
		wp = 1;
		while (ap || wp) begin
			@(negedge sys_clk);
			ah = ap && awready === 1'b1;
			wh = wp && wready === 1'b1;
			@(posedge sys_clk);
			if (ah) begin
				awvalid <= 0;
				ap = 0;
			end
			if (wh) begin
				wvalid <= 0;
				wp = 0;
			end
		end
		do begin
			@(negedge sys_clk);
			b = bvalid === 1'b1;
			r = bresp;
			@(posedge sys_clk);
		end while (!b);
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(negedge sys_clk);
			h = arready === 1'b1;
			@(posedge sys_clk);
		end while (!h);
		arvalid <= 0;
		do begin
			@(negedge sys_clk);
			h = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
		end while (!h);
		rready <= 0;
	endtask
	task automatic set_mode(input logic [1:0] m);
		want_mode <= m;
		cyc(3);
		@(negedge sys_clk);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		axi_rd(mfs_pkg::CONFIG_ADDR, rd, rs);
		chk_word(rd, {24'h0, mfs_pkg::CFG_DIV_RESET}, "config reset");
		axi_rd(mfs_pkg::CTRL_ADDR, rd, rs);
		chk_word(rd, 32'h0, "control reads zero");
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h08, "reset status");
		axi_rd(8'h0C, rd, rs);
		chk_bits(rs, mfs_pkg::AXI_SLVERR, "unmapped read");
		axi_wr(8'h10, 32'h0, rs);
		chk_bits(rs, mfs_pkg::AXI_SLVERR, "unmapped write");
		axi_wr(mfs_pkg::CONFIG_ADDR, 32'h0, rs);
		chk_bits(rs, mfs_pkg::AXI_OKAY, "config write");
		// Divider zero gives one tick a cycle, which the overcurrent timing below relies on.
		axi_rd(mfs_pkg::CONFIG_ADDR, rd, rs);
		chk_word(rd, 32'h0, "config readback");
	endtask
	task automatic t_thermal();
		set_mode(mfs_pkg::MODE_TWO_PHASE);
		chk_bits(bridge_enable, 2'h3, "drive on");
		@(posedge sys_clk) thermal_trip <= 1;
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h0, "thermal off");
		@(posedge sys_clk) thermal_trip <= 0;
		cyc(4);
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h0, "thermal held");
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h01, "thermal status");
		set_mode(mfs_pkg::MODE_STANDBY);
		chk_bits(bridge_enable, 2'h0, "standby bridge");
		chk_bits({1'b0, chopper_oscillator}, 2'h0, "standby osc");
		set_mode(mfs_pkg::MODE_ONE_TWO);
		chk_bits(bridge_enable, 2'h3, "thermal cleared");
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h30, "bridges in status");
		drive_request <= 2'h1;
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h1, "one phase requested");
		@(posedge sys_clk) drive_request <= 2'h3;
		thermal_trip <= 1;
		@(posedge sys_clk) thermal_trip <= 0;
		axi_wr(mfs_pkg::CTRL_ADDR, 32'h1, rs);
		chk_bits(rs, mfs_pkg::AXI_OKAY, "clear write");
		cyc(2);
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h3, "software clear");
	endtask
	task automatic t_overcurrent();
		int n;
		@(posedge sys_clk) overcurrent_trip <= 2'h2;
		cyc(2);
		overcurrent_trip <= 2'h0;
		cyc(10);
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h3, "short pulse ignored");
		@(posedge sys_clk) overcurrent_trip <= 2'h1;
		cyc(2);
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h3, "still masked");
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h3, "mask not yet done");
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h2, "own phase off");
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h0, "overcurrent off");
		@(posedge sys_clk) overcurrent_trip <= 2'h0;
		cyc(5);
		@(negedge sys_clk) chk_bits(bridge_enable, 2'h0, "latch held");
		chk_bits({1'b0, chopper_oscillator}, 2'h0, "osc stopped");
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h0A, "oc status");
		set_mode(mfs_pkg::MODE_STANDBY);
		@(posedge sys_clk) want_mode <= mfs_pkg::MODE_W_ONE_TWO;
		for (n = 0; n < 10 && bridge_enable !== 2'h3; n++) @(negedge sys_clk);
		chk_bits(bridge_enable, 2'h3, "resume");
		@(negedge sys_clk) chk_bits({1'b0, chopper_oscillator}, 2'h1, "osc resumed");
		@(posedge sys_clk) overcurrent_trip <= 2'h2;
		for (n = 0; n < 20 && bridge_enable !== 2'h0; n++) @(negedge sys_clk);
		chk_bits(bridge_enable, 2'h0, "phase b off");
		@(posedge sys_clk) overcurrent_trip <= 2'h0;
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h0C, "phase b status");
		set_mode(mfs_pkg::MODE_STANDBY);
		axi_rd(mfs_pkg::STATUS_ADDR, rd, rs);
		chk_word(rd, 32'h08, "phase b cleared");
	endtask
	// ==========================================================
	// Run control
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The ceiling is tens of times the length of the scenarios.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end
	initial begin
		cyc(10);
		reset_n <= 1;
		t_regs();
		t_thermal();
		t_overcurrent();
		summarize();
	end
endmodule
